/* File: hdl/bridge_command_status_control.sv */
`timescale 1ns/1ps
module bridge_command_status_control
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // configuration access
  input  wire logic        cfg_wr_en,
  input  wire logic        cfg_rd_en,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_byte_en,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rd_valid,
  // downstream requests from the express side
  input  wire logic        dn_req_valid,
  input  wire logic        dn_req_io,
  input  wire logic        dn_req_write,
  input  wire logic        dn_req_poisoned,
  output logic             pci_fwd_valid,
  output logic             pci_fwd_io,
  output logic             pci_fwd_wi_promote,
  output logic             pci_fwd_bad_parity,
  output logic             dn_ur_valid,
  // upstream requests from the secondary bus
  input  wire logic        sec_req_valid,
  output logic             up_fwd_valid,
  output logic             sec_claim_enable,
  // completions and errors
  input  wire logic        cpl_ur_rcvd,
  input  wire logic        cpl_ca_rcvd,
  input  wire logic        sec_serr_n,
  output logic             err_msg_valid,
  // register views
  output logic [15:0]      bridge_command,
  output logic [15:0]      bridge_status
);
  import bridge_cfg_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic [15:0] sts_q;
  logic [15:0] sts_d;
  logic [15:0] cmd_be_mask;
  logic [15:0] sts_be_mask;
  logic        hit;
  logic        serr_meta_q;
  logic        serr_sync_q;
  logic        serr_prev_q;
  logic        serr_event;
  logic        mem_ok;
  logic        io_ok;
  logic        poison_in;

  assign hit         = (cfg_addr == CMDSTS_DWORD);
  assign cmd_be_mask = {{8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};
  assign sts_be_mask = {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}}};
  assign mem_ok      = cmd_q[CMD_MEM_SPACE];
  assign io_ok       = cmd_q[CMD_IO_SPACE];
  assign poison_in   = dn_req_valid && dn_req_poisoned;

  // ----------------------------------------------------------------
  // command register
  // ----------------------------------------------------------------
  always_comb
  begin
    cmd_d = cmd_q;
    if (cfg_wr_en && hit)
    begin
      // only writable bits move; fixed bits keep their zero
      cmd_d = (cmd_q & ~(CMD_WR_MASK & cmd_be_mask))
            | (cfg_wdata[15:0] & CMD_WR_MASK & cmd_be_mask);
    end
    cmd_d = cmd_d & CMD_WR_MASK;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      cmd_q <= CMD_RESET;
    else
      cmd_q <= cmd_d;
  end

  // ----------------------------------------------------------------
  // secondary error pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      serr_meta_q <= 1'b1;
      serr_sync_q <= 1'b1;
      serr_prev_q <= 1'b1;
    end
    else
    begin
      serr_meta_q <= sec_serr_n;
      serr_sync_q <= serr_meta_q;
      serr_prev_q <= serr_sync_q;
    end
  end

  // one report per falling edge of the pin
  assign serr_event = serr_prev_q && !serr_sync_q;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      err_msg_valid <= 1'b0;
    else
      err_msg_valid <= serr_event && cmd_q[CMD_SYS_ERR_RPT];
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  always_comb
  begin
    sts_d = sts_q;
    if (cfg_wr_en && hit)
      sts_d = sts_q & ~(cfg_wdata[31:16] & STS_W1C_MASK & sts_be_mask);
    // sets come after the clear so an event in the clear cycle survives
    if (poison_in)
      sts_d[STS_PAR_DETECTED] = 1'b1;
    if (poison_in && cmd_q[CMD_PARITY_RESP])
      sts_d[STS_MASTER_PAR] = 1'b1;
    if (serr_event && cmd_q[CMD_SYS_ERR_RPT])
      sts_d[STS_SYS_ERR_SENT] = 1'b1;
    if (cpl_ur_rcvd)
      sts_d[STS_MST_ABORT_RX] = 1'b1;
    if (cpl_ca_rcvd)
      sts_d[STS_TGT_ABORT_RX] = 1'b1;
    sts_d = (sts_d & STS_W1C_MASK) | STS_RESET;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      sts_q <= STS_RESET;
    else
      sts_q <= sts_d;
  end

  // ----------------------------------------------------------------
  // configuration read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_rdata    <= 32'h0000_0000;
      cfg_rd_valid <= 1'b0;
    end
    else
    begin
      cfg_rd_valid <= cfg_rd_en;
      if (cfg_rd_en && hit)
        cfg_rdata <= {sts_q, cmd_q};
      else
        cfg_rdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bridge_command <= CMD_RESET;
      bridge_status  <= STS_RESET;
    end
    else
    begin
      bridge_command <= cmd_d;
      bridge_status  <= sts_d;
    end
  end

  // ----------------------------------------------------------------
  // downstream steering
  // ----------------------------------------------------------------
  // special cycles have no path here: nothing is decoded for them
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pci_fwd_valid      <= 1'b0;
      pci_fwd_io         <= 1'b0;
      pci_fwd_wi_promote <= 1'b0;
      pci_fwd_bad_parity <= 1'b0;
      dn_ur_valid        <= 1'b0;
    end
    else
    begin
      pci_fwd_valid <= dn_req_valid
                       && (dn_req_io ? io_ok : mem_ok);
      dn_ur_valid   <= dn_req_valid
                       && (dn_req_io ? !io_ok : !mem_ok);
      pci_fwd_io    <= dn_req_io;
      pci_fwd_wi_promote <= dn_req_valid && !dn_req_io && dn_req_write
                            && mem_ok && cmd_q[CMD_WI_PROMOTE];
      // poison is passed on whatever the parity response setting
      pci_fwd_bad_parity <= poison_in
                            && (dn_req_io ? io_ok : mem_ok);
    end
  end

  // ----------------------------------------------------------------
  // upstream steering
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      up_fwd_valid     <= 1'b0;
      sec_claim_enable <= 1'b0;
    end
    else
    begin
      up_fwd_valid     <= sec_req_valid && cmd_q[CMD_INITIATOR];
      sec_claim_enable <= cmd_d[CMD_INITIATOR];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence mem_req_off;
    dn_req_valid && !dn_req_io && !cmd_q[CMD_MEM_SPACE];
  endsequence

  sequence io_req_off;
    dn_req_valid && dn_req_io && !cmd_q[CMD_IO_SPACE];
  endsequence

  a_fixed_bits_zero: assert property (
    (cfg_rd_valid && $past(hit)) |-> cfg_rdata[15:9] == 7'h00
    && cfg_rdata[7] == 1'b0 && cfg_rdata[5] == 1'b0
    && cfg_rdata[3] == 1'b0)
    else $error("fixed command bits read nonzero");

  a_mem_off_ur: assert property (
    mem_req_off |=> dn_ur_valid && !pci_fwd_valid)
    else $error("memory request not refused while disabled");

  a_io_off_ur: assert property (
    io_req_off |=> dn_ur_valid && !pci_fwd_valid)
    else $error("io request not refused while disabled");

  a_mem_on_fwd: assert property (
    (dn_req_valid && !dn_req_io && cmd_q[CMD_MEM_SPACE])
    |=> pci_fwd_valid && !dn_ur_valid)
    else $error("memory request not forwarded");

  a_par_flag_gate: assert property (
    (poison_in && !cmd_q[CMD_PARITY_RESP] && !sts_q[STS_MASTER_PAR])
    |=> !sts_q[STS_MASTER_PAR])
    else $error("parity flag set while response disabled");

  a_par_flag_set: assert property (
    (poison_in && cmd_q[CMD_PARITY_RESP]) |=> sts_q[STS_MASTER_PAR])
    else $error("parity flag missed");

  a_poison_forward: assert property (
    (poison_in && !dn_req_io && cmd_q[CMD_MEM_SPACE])
    |=> pci_fwd_bad_parity)
    else $error("poisoned request lost its bad parity");

  a_serr_report: assert property (
    $fell(serr_sync_q) |=> err_msg_valid == $past(cmd_q[CMD_SYS_ERR_RPT]))
    else $error("system error report does not follow enable");

  a_initiator_gate: assert property (
    !cmd_q[CMD_INITIATOR] |=> !up_fwd_valid)
    else $error("upstream forward while initiator disabled");

  a_wi_promote: assert property (
    pci_fwd_wi_promote |-> $past(cmd_q[CMD_WI_PROMOTE]) && pci_fwd_valid)
    else $error("promotion without enable");

  a_status_cap: assert property (
    bridge_status[STS_CAP_LIST] ##1 bridge_status[STS_CAP_LIST])
    else $error("capability bit dropped");

  a_status_w1c: assert property (
    (cfg_wr_en && hit && cfg_byte_en[3] && cfg_wdata[31]
     && !poison_in) |=> !sts_q[STS_PAR_DETECTED])
    else $error("status bit not cleared by write of one");

  sequence serr_pin_fall;
    $fell(serr_meta_q);
  endsequence

  sequence serr_armed;
    serr_pin_fall ##1 cmd_q[CMD_SYS_ERR_RPT];
  endsequence

  a_serr_latency: assert property (
    serr_armed |=> err_msg_valid && sts_q[STS_SYS_ERR_SENT])
    else $error("system error not reported in time");

  a_serr_quiet: assert property (
    !cmd_q[CMD_SYS_ERR_RPT] |=> !err_msg_valid)
    else $error("system error reported while disabled");

  a_io_on_fwd: assert property (
    (dn_req_valid && dn_req_io && cmd_q[CMD_IO_SPACE])
    |=> pci_fwd_valid && pci_fwd_io && !dn_ur_valid)
    else $error("io request not forwarded");

  a_initiator_fwd: assert property (
    (sec_req_valid && cmd_q[CMD_INITIATOR]) |=> up_fwd_valid)
    else $error("secondary request not forwarded upstream");

  a_poison_io: assert property (
    (poison_in && dn_req_io && cmd_q[CMD_IO_SPACE]) |=> pci_fwd_bad_parity)
    else $error("poisoned io request lost its bad parity");

  a_wi_promote_on: assert property (
    (dn_req_valid && !dn_req_io && dn_req_write && cmd_q[CMD_MEM_SPACE]
     && cmd_q[CMD_WI_PROMOTE]) |=> pci_fwd_wi_promote)
    else $error("memory write not promoted");

  a_cmd_fixed_zero: assert property (
    (bridge_command & ~CMD_WR_MASK) == 16'h0000)
    else $error("fixed command bits nonzero");

  a_cmd_hold: assert property (
    !(cfg_wr_en && hit) |=> cmd_q == $past(cmd_q))
    else $error("command changed without a mapped write");

  a_cmd_write: assert property (
    (cfg_wr_en && hit && cfg_byte_en[0])
    |=> cmd_q[7:0] == ($past(cfg_wdata[7:0]) & CMD_WR_MASK[7:0]))
    else $error("command low byte write lost");

  a_rd_data: assert property (
    (cfg_rd_en && hit)
    |=> cfg_rd_valid && cfg_rdata == {$past(sts_q), $past(cmd_q)})
    else $error("read data does not match registers");

  a_abort_flags: assert property (
    (cpl_ur_rcvd && cpl_ca_rcvd)
    |=> sts_q[STS_MST_ABORT_RX] && sts_q[STS_TGT_ABORT_RX])
    else $error("completion status flags not set");

  a_set_wins: assert property (
    (poison_in && cfg_wr_en && hit && cfg_byte_en[3] && cfg_wdata[31])
    |=> sts_q[STS_PAR_DETECTED])
    else $error("clear in the event cycle lost the flag");

endmodule // bridge_command_status_control

/* File: hdl/bridge_cfg_pkg.sv */
package bridge_cfg_pkg;

  // ----------------------------------------------------------------
  // configuration map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_OFFSET     = 8'h04;
  localparam logic [7:0]  STS_OFFSET     = 8'h06;
  localparam logic [7:0]  CMDSTS_DWORD   = 8'h04;
  localparam logic [15:0] CMD_RESET      = 16'h0000;
  localparam logic [15:0] STS_RESET      = 16'h0010;
  // writable command bits: 8, 6, 4, 2, 1, 0
  localparam logic [15:0] CMD_WR_MASK    = 16'h0157;
  // write-one-clear status bits: 15, 14, 13, 12, 8
  localparam logic [15:0] STS_W1C_MASK   = 16'hF100;

  // ----------------------------------------------------------------
  // command fields
  // ----------------------------------------------------------------
  localparam int CMD_IO_SPACE      = 0;
  localparam int CMD_MEM_SPACE     = 1;
  localparam int CMD_INITIATOR     = 2;
  localparam int CMD_WI_PROMOTE    = 4;
  localparam int CMD_PARITY_RESP   = 6;
  localparam int CMD_SYS_ERR_RPT   = 8;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int STS_CAP_LIST      = 4;
  localparam int STS_MASTER_PAR    = 8;
  localparam int STS_TGT_ABORT_RX  = 12;
  localparam int STS_MST_ABORT_RX  = 13;
  localparam int STS_SYS_ERR_SENT  = 14;
  localparam int STS_PAR_DETECTED  = 15;

endpackage

/* File: verification/pci_serr_source.sv */
`timescale 1ns/1ps
module pci_serr_source
(
  // clock
  input  wire logic clock,
  // request from the bench
  input  wire logic fire,
  // open-drain error pin
  output logic      serr_n
);
  // pull-up holds the pin high whenever no agent pulls it low
  initial serr_n = 1'b1;
  always @(posedge clock)
  begin
    serr_n <= ~fire;
  end
endmodule // pci_serr_source

/* File: verification/bridge_command_status_control_tb.sv */
`timescale 1ns/1ps
module bridge_command_status_control_tb;
  import bridge_cfg_pkg::*;
  typedef struct packed
  {
    logic [15:0] cmd;
    logic        io;
    logic        wr;
    logic        pois;
    logic [4:0]  exp;
  } row_t;
  logic        clock, reset_n, cfg_wr_en, cfg_rd_en, fire, sec_serr_n;
  logic        dn_req_valid, dn_req_io, dn_req_write, dn_req_poisoned;
  logic        sec_req_valid, cpl_ur_rcvd, cpl_ca_rcvd, seen;
  logic        cfg_rd_valid, pci_fwd_valid, pci_fwd_io, dn_ur_valid;
  logic        pci_fwd_wi_promote, pci_fwd_bad_parity;
  logic        up_fwd_valid, sec_claim_enable, err_msg_valid;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [15:0] bridge_command, bridge_status;
  int          num_errors, n_checks;
  // expected: {fwd, fwd_io, promote, bad_parity, unsupported}
  row_t        rows [10] = '{
    '{16'h0000, 1'b0, 1'b1, 1'b0, 5'h01}, '{16'h0002, 1'b0, 1'b1, 1'b0, 5'h10},
    '{16'h0012, 1'b0, 1'b1, 1'b0, 5'h14}, '{16'h0012, 1'b0, 1'b0, 1'b0, 5'h10},
    '{16'h0002, 1'b1, 1'b1, 1'b0, 5'h01}, '{16'h0001, 1'b1, 1'b1, 1'b0, 5'h18},
    '{16'h0013, 1'b1, 1'b1, 1'b0, 5'h18}, '{16'h0002, 1'b0, 1'b0, 1'b1, 5'h12},
    '{16'h0042, 1'b0, 1'b0, 1'b1, 5'h12}, '{16'h0001, 1'b0, 1'b0, 1'b1, 5'h01}};

  bridge_command_status_control uut
  (
    .clock(clock), .reset_n(reset_n), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
    .dn_req_valid(dn_req_valid), .dn_req_io(dn_req_io),
    .dn_req_write(dn_req_write), .dn_req_poisoned(dn_req_poisoned),
    .pci_fwd_valid(pci_fwd_valid), .pci_fwd_io(pci_fwd_io),
    .pci_fwd_wi_promote(pci_fwd_wi_promote),
    .pci_fwd_bad_parity(pci_fwd_bad_parity), .dn_ur_valid(dn_ur_valid),
    .sec_req_valid(sec_req_valid), .up_fwd_valid(up_fwd_valid),
    .sec_claim_enable(sec_claim_enable), .cpl_ur_rcvd(cpl_ur_rcvd),
    .cpl_ca_rcvd(cpl_ca_rcvd), .sec_serr_n(sec_serr_n),
    .err_msg_valid(err_msg_valid), .bridge_command(bridge_command),
    .bridge_status(bridge_status)
  );
  pci_serr_source serr_src
  (
    .clock(clock), .fire(fire), .serr_n(sec_serr_n)
  );

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    {cfg_wr_en, cfg_addr, cfg_byte_en, cfg_wdata} = {1'b1, a, be, d};
    tick;
    cfg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    {cfg_rd_en, cfg_addr} = {1'b1, a};
    tick;
    cfg_rd_en = 1'b0;
    chk(cfg_rdata, exp);
  endtask
  task automatic req(input logic io, input logic w, input logic p);
    {dn_req_valid, dn_req_io} = {1'b1, io};
    {dn_req_write, dn_req_poisoned} = {w, p};
    tick;
    dn_req_valid = 1'b0;
  endtask
  // one pin pulse, then watch long enough for the two-flop synchroniser
  task automatic serr;
    fire = 1'b1;
    tick;
    fire = 1'b0;
    seen = 1'b0;
    repeat (8)
    begin
      tick;
      if (err_msg_valid === 1'b1)
        seen = 1'b1;
    end
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial
  begin
    #20000;
    num_errors++;
    tally_and_finish;
  end
  initial
  begin
    {reset_n, cfg_wr_en, cfg_rd_en, fire, dn_req_valid, dn_req_io} = '0;
    {dn_req_write, dn_req_poisoned, sec_req_valid} = '0;
    {cpl_ur_rcvd, cpl_ca_rcvd, cfg_addr, cfg_byte_en, cfg_wdata} = '0;
    repeat (3) @(posedge clock);
    #1;
    reset_n = 1'b1;
    tick;
    rd(8'h04, 32'h0010_0000);
    chk(cfg_rd_valid, 1'b1);
    foreach (rows[i])
    begin
      wr(8'h04, 4'h3, {16'h0, rows[i].cmd});
      req(rows[i].io, rows[i].wr, rows[i].pois);
      chk({pci_fwd_valid, pci_fwd_io & pci_fwd_valid, pci_fwd_wi_promote},
          rows[i].exp[4:2]);
      chk({pci_fwd_bad_parity, dn_ur_valid},
          rows[i].exp[1:0]);
    end
    // write-one-clear of every status bit; bit 4 must survive
    wr(8'h04, 4'hC, 32'hFFFF_0000);
    chk(bridge_status, 16'h0010);
    // idle edge so the write strobe is not dropped and raised at once
    tick;
    wr(8'h04, 4'h3, 32'h0000_0002);
    req(1'b0, 1'b1, 1'b1);
    rd(8'h04, 32'h8010_0002);
    wr(8'h04, 4'h3, 32'h0000_0042);
    req(1'b0, 1'b1, 1'b1);
    {cpl_ur_rcvd, cpl_ca_rcvd} = 2'b11;
    tick;
    {cpl_ur_rcvd, cpl_ca_rcvd} = 2'b00;
    tick;
    rd(8'h04, 32'hB110_0042);
    wr(8'h04, 4'hF, 32'hFFFF_0000);
    chk(bridge_status, 16'h0010);
    serr;
    chk({seen, bridge_status}, 17'h0_0010);
    wr(8'h04, 4'h3, 32'h0000_0100);
    serr;
    chk({seen, bridge_status}, 17'h1_4010);
    wr(8'h04, 4'h3, 32'h0);
    sec_req_valid = 1'b1;
    tick;
    chk({up_fwd_valid, sec_claim_enable}, 2'b00);
    wr(8'h04, 4'h3, 32'h0000_0004);
    tick;
    chk({up_fwd_valid, sec_claim_enable}, 2'b11);
    sec_req_valid = 1'b0;
    wr(8'h04, 4'h3, 32'h0000_FFFF);
    rd(8'h04, 32'h4010_0157);
    chk(bridge_command, 16'h0157);
    wr(8'h08, 4'hF, 32'h0);
    chk(bridge_command, 16'h0157);
    rd(8'h08, 32'h0);
    // second reset in mid-run clears the enables again
    reset_n = 1'b0;
    tick;
    chk({bridge_command, bridge_status}, 32'h0000_0010);
    reset_n = 1'b1;
    tick;
    rd(8'h04, 32'h0010_0000);
    chk(sec_claim_enable, 1'b0);
    tally_and_finish;
  end
endmodule // bridge_command_status_control_tb
